// File: core/iscp_cfg.svh
// Notes on behaviour
// - write: address with direction low, then bytes
// - command byte selects register for next data
// - stop after command only stores the pointer
// - first data byte goes to selected register
// - later data bytes follow the pointer, which advances only inside its group
// - read starts at the stored pointer
// - pointer advances after every transmitted byte inside its group
// - master sets pointer before reading any bytes; the bench also reads once at the pointer the last write left
// - master rewrites command before read-back verification
// - multi-master reads join with repeated start
// - pointer wraps inside its register group
// - own address decoded from three select pins
// - eighth bit is direction, high means read
// - pointer cycles 0x10..0x13, elsewhere stays put
// - device acknowledges its own address and every received data byte
`ifndef ISCP_CFG_SVH
`define ISCP_CFG_SVH

// pointer reset value and the autoincrement group
`define ISCP_PTR_RESET 8'h00
`define ISCP_GRP_BASE  8'h10
`define ISCP_GRP_TOP   8'h13

// bit counts of one byte on the wire
`define ISCP_BYTE_BITS 4'h8
`define ISCP_ACK_BIT   4'h8

// master bit timing: one bus bit is four quarter steps
`define ISCP_CLK_NS    10
`define ISCP_SCL_NS    2500
`define ISCP_QTR_CYC   ((`ISCP_SCL_NS / 4) / `ISCP_CLK_NS)

`endif

// File: core/iscp_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "iscp_cfg.svh"

module iscp_device (
  iscp_if.device             link,
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic          ce,
  input  wire logic [1:0]    addr_select_pin_low,
  input  wire logic [1:0]    addr_select_pin_mid,
  input  wire logic [1:0]    addr_select_pin_high,
  input  wire logic [7:0]    rd_data,
  output logic               wr_strobe,
  output logic [7:0]         wr_addr,
  output logic [7:0]         wr_data,
  output logic [7:0]         rd_addr,
  output logic               busy
);

  // pointer step: cycle inside the intensity group, hold elsewhere
  function automatic logic [7:0] ptr_step(input logic [7:0] p);
    logic in_grp;
    in_grp = (p >= `ISCP_GRP_BASE) && (p <= `ISCP_GRP_TOP);
    if (!in_grp)
      ptr_step = p;
    else if (p == `ISCP_GRP_TOP)
      ptr_step = `ISCP_GRP_BASE;
    else
      ptr_step = p + 8'h01;
  endfunction

  iscp_pkg::iscp_dev_state_e state_r, state_nxt;

  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [1:0] pin_lo_q1, pin_lo_q2;
  logic [1:0] pin_mi_q1, pin_mi_q2;
  logic [1:0] pin_hi_q1, pin_hi_q2;
  logic [6:0] own_addr_r;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic       rw_r, rw_nxt;
  logic       cmd_r, cmd_nxt;
  logic       nack_r, nack_nxt;
  logic       sda_oe_r, sda_oe_nxt;
  logic       wr_r, wr_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [7:0] wr_data_r, wr_data_nxt;
  logic       busy_r;

  // line events, read only from the second and third sync stage
  wire scl_rise  = scl_q[1] & ~scl_q[2];
  wire scl_fall  = ~scl_q[1] & scl_q[2];
  wire scl_high  = scl_q[1] & scl_q[2];
  wire start_det = scl_high & sda_q[2] & ~sda_q[1];
  wire stop_det  = scl_high & ~sda_q[2] & sda_q[1];
  wire sda_bit   = sda_q[1];
  wire byte_done = (cnt_r == `ISCP_BYTE_BITS);

  // select pin decode; strap bit1 fills address bits 6:3, a bus-strapped mid pin gives 01 in 5:4
  wire [6:0] pin_addr = {pin_hi_q2[1], ~pin_mi_q2[1], pin_mi_q2[1],
                         pin_lo_q2[1], pin_hi_q2[0], pin_mi_q2[0],
                         pin_lo_q2[0]};
  wire addr_hit = (shift_r[7:1] == own_addr_r);

  // three-stage synchronisers for the bus lines, two-stage for the straps
  always_ff @(posedge clock) begin
    if (reset) begin
      scl_q     <= 3'h7;
      sda_q     <= 3'h7;
      pin_lo_q1 <= 2'h0;
      pin_lo_q2 <= 2'h0;
      pin_mi_q1 <= 2'h0;
      pin_mi_q2 <= 2'h0;
      pin_hi_q1 <= 2'h0;
      pin_hi_q2 <= 2'h0;
      own_addr_r <= 7'h00;
    end else if (ce) begin
      scl_q     <= {scl_q[1:0], link.scl};
      sda_q     <= {sda_q[1:0], link.sda};
      pin_lo_q1 <= addr_select_pin_low;
      pin_lo_q2 <= pin_lo_q1;
      pin_mi_q1 <= addr_select_pin_mid;
      pin_mi_q2 <= pin_mi_q1;
      pin_hi_q1 <= addr_select_pin_high;
      pin_hi_q2 <= pin_hi_q1;
      own_addr_r <= pin_addr;
    end
  end

  // bit and byte sequencing; bits are taken on scl rise and the
  // line is changed only on scl fall so data is stable while high
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    shift_nxt   = shift_r;
    ptr_nxt     = ptr_r;
    rw_nxt      = rw_r;
    cmd_nxt     = cmd_r;
    nack_nxt    = nack_r;
    sda_oe_nxt  = sda_oe_r;
    wr_nxt      = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    if (stop_det) begin
      // a stop ends any transfer; the pointer keeps its value
      state_nxt  = iscp_pkg::ISCP_D_IDLE;
      sda_oe_nxt = 1'b0;
    end else if (start_det) begin
      // start or repeated start: next byte is an address
      state_nxt  = iscp_pkg::ISCP_D_ADDR;
      cnt_nxt    = 4'h0;
      cmd_nxt    = 1'b1;
      sda_oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        iscp_pkg::ISCP_D_IDLE: begin
          sda_oe_nxt = 1'b0;
        end
        iscp_pkg::ISCP_D_ADDR,
        iscp_pkg::ISCP_D_RX: begin
          if (scl_rise && !byte_done) begin
            shift_nxt = {shift_r[6:0], sda_bit};
            cnt_nxt   = cnt_r + 4'h1;
          end else if (scl_fall && byte_done) begin
            cnt_nxt = 4'h0;
            if (state_r == iscp_pkg::ISCP_D_ADDR) begin
              if (addr_hit) begin
                state_nxt  = iscp_pkg::ISCP_D_ACK;
                sda_oe_nxt = 1'b1;
                rw_nxt     = shift_r[0];
              end else begin
                state_nxt = iscp_pkg::ISCP_D_IDLE;
              end
            end else begin
              state_nxt  = iscp_pkg::ISCP_D_ACK;
              sda_oe_nxt = 1'b1;
              if (cmd_r) begin
                // first byte after the address is the command
                ptr_nxt = shift_r;
                cmd_nxt = 1'b0;
              end else begin
                wr_nxt      = 1'b1;
                wr_addr_nxt = ptr_r;
                wr_data_nxt = shift_r;
                ptr_nxt     = ptr_step(ptr_r);
              end
            end
          end
        end
        iscp_pkg::ISCP_D_ACK: begin
          // hold sda low through the ninth clock, then move on
          if (scl_fall) begin
            if (rw_r) begin
              state_nxt  = iscp_pkg::ISCP_D_TX;
              shift_nxt  = rd_data;
              sda_oe_nxt = ~rd_data[7];
            end else begin
              state_nxt  = iscp_pkg::ISCP_D_RX;
              sda_oe_nxt = 1'b0;
            end
          end
        end
        iscp_pkg::ISCP_D_TX: begin
          if (scl_rise && !byte_done) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (byte_done) begin
              state_nxt  = iscp_pkg::ISCP_D_MACK;
              cnt_nxt    = 4'h0;
              sda_oe_nxt = 1'b0;
              ptr_nxt    = ptr_step(ptr_r);
            end else begin
              shift_nxt  = {shift_r[6:0], 1'b0};
              sda_oe_nxt = ~shift_r[6];
            end
          end
        end
        iscp_pkg::ISCP_D_MACK: begin
          // master ack: low asks for another byte, high ends the read
          if (scl_rise) begin
            nack_nxt = sda_bit;
          end else if (scl_fall) begin
            if (nack_r) begin
              state_nxt = iscp_pkg::ISCP_D_IDLE;
            end else begin
              state_nxt  = iscp_pkg::ISCP_D_TX;
              shift_nxt  = rd_data;
              sda_oe_nxt = ~rd_data[7];
            end
          end
        end
      endcase
    end
  end

  // state registers; pointer has a fixed value until a command lands
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r   <= iscp_pkg::ISCP_D_IDLE;
      cnt_r     <= 4'h0;
      shift_r   <= 8'h00;
      ptr_r     <= `ISCP_PTR_RESET;
      rw_r      <= 1'b0;
      cmd_r     <= 1'b0;
      nack_r    <= 1'b1;
      sda_oe_r  <= 1'b0;
      wr_r      <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      busy_r    <= 1'b0;
    end else if (ce) begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      shift_r   <= shift_nxt;
      ptr_r     <= ptr_nxt;
      rw_r      <= rw_nxt;
      cmd_r     <= cmd_nxt;
      nack_r    <= nack_nxt;
      sda_oe_r  <= sda_oe_nxt;
      wr_r      <= wr_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
      busy_r    <= (state_nxt != iscp_pkg::ISCP_D_IDLE);
    end
  end

  // open drain: the data output level is always low, oe does the work
  assign link.s_sda_o  = 1'b0;
  assign link.s_sda_oe = sda_oe_r;
  assign wr_strobe     = wr_r;
  assign wr_addr       = wr_addr_r;
  assign wr_data       = wr_data_r;
  assign rd_addr       = ptr_r;   // user answers rd_data from this
  assign busy          = busy_r;

endmodule

`default_nettype wire

// File: core/iscp_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "iscp_cfg.svh"

module iscp_host #(
  parameter int QTR_CYC = `ISCP_QTR_CYC
) (
  iscp_if.host                 link,
  input  wire logic            clock,
  input  wire logic            reset,
  input  wire logic            ce,
  input  wire logic            cmd_valid,
  input  wire iscp_pkg::iscp_op_e cmd_op,
  input  wire logic [7:0]      cmd_data,
  input  wire logic            cmd_last,
  output logic                 cmd_ready,
  output logic                 done,
  output logic [7:0]           rx_data,
  output logic                 nack
);

  iscp_pkg::iscp_host_state_e state_r, state_nxt;

  logic [1:0]  sda_q;
  logic [15:0] qcnt_r;
  logic [1:0]  phase_r, phase_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [8:0]  tx_r, tx_nxt;
  logic [8:0]  rx_r, rx_nxt;
  logic        scl_oe_r, scl_oe_nxt;
  logic        sda_oe_r, sda_oe_nxt;
  logic        ready_r, ready_nxt;
  logic        done_r, done_nxt;
  logic [7:0]  rx_data_r, rx_data_nxt;
  logic        nack_r, nack_nxt;

  // the bus clock is made here by dividing the system clock
  wire active = (state_r == iscp_pkg::ISCP_H_START) ||
                (state_r == iscp_pkg::ISCP_H_BIT) ||
                (state_r == iscp_pkg::ISCP_H_STOP);
  wire tick   = active && (qcnt_r == 16'(QTR_CYC - 1));
  wire held   = (state_r == iscp_pkg::ISCP_H_HOLD);
  wire take   = cmd_valid && ready_r;

  // quarter-step sequencing of start, bits and stop
  always_comb begin
    state_nxt   = state_r;
    phase_nxt   = phase_r;
    bit_nxt     = bit_r;
    tx_nxt      = tx_r;
    rx_nxt      = rx_r;
    scl_oe_nxt  = scl_oe_r;
    sda_oe_nxt  = sda_oe_r;
    ready_nxt   = ready_r;
    done_nxt    = 1'b0;
    rx_data_nxt = rx_data_r;
    nack_nxt    = nack_r;
    unique case (state_r)
      iscp_pkg::ISCP_H_IDLE,
      iscp_pkg::ISCP_H_HOLD: begin
        if (take) begin
          ready_nxt = 1'b0;
          phase_nxt = 2'h0;
          bit_nxt   = 4'h0;
          unique case (cmd_op)
            iscp_pkg::ISCP_OP_START: begin
              // from hold this is a repeated start, keeping the bus
              state_nxt = iscp_pkg::ISCP_H_START;
              tx_nxt    = {cmd_data, 1'b1};
            end
            iscp_pkg::ISCP_OP_WRITE: begin
              state_nxt = held ? iscp_pkg::ISCP_H_BIT : state_r;
              tx_nxt    = {cmd_data, 1'b1};
            end
            iscp_pkg::ISCP_OP_READ: begin
              state_nxt = held ? iscp_pkg::ISCP_H_BIT : state_r;
              tx_nxt    = {8'hff, cmd_last};
            end
            iscp_pkg::ISCP_OP_STOP: begin
              state_nxt = held ? iscp_pkg::ISCP_H_STOP : state_r;
            end
          endcase
          // a byte or stop with no open transfer is refused at once
          if (!held && cmd_op != iscp_pkg::ISCP_OP_START) begin
            ready_nxt = 1'b1;
            done_nxt  = 1'b1;
            nack_nxt  = 1'b1;
          end
        end
      end
      iscp_pkg::ISCP_H_START: begin
        if (tick) begin
          phase_nxt = phase_r + 2'h1;
          unique case (phase_r)
            2'h0: sda_oe_nxt = 1'b0;
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: sda_oe_nxt = 1'b1;   // sda falls while scl high
            2'h3: begin
              scl_oe_nxt = 1'b1;
              state_nxt  = iscp_pkg::ISCP_H_BIT;
            end
          endcase
        end
      end
      iscp_pkg::ISCP_H_BIT: begin
        if (tick) begin
          phase_nxt = phase_r + 2'h1;
          unique case (phase_r)
            2'h0: sda_oe_nxt = ~tx_r[8];
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: rx_nxt = {rx_r[7:0], sda_q[1]};
            2'h3: begin
              scl_oe_nxt = 1'b1;
              tx_nxt     = {tx_r[7:0], 1'b1};
              bit_nxt    = bit_r + 4'h1;
              if (bit_r == `ISCP_ACK_BIT) begin
                state_nxt   = iscp_pkg::ISCP_H_HOLD;
                ready_nxt   = 1'b1;
                done_nxt    = 1'b1;
                rx_data_nxt = rx_r[8:1];
                nack_nxt    = rx_r[0];
              end
            end
          endcase
        end
      end
      iscp_pkg::ISCP_H_STOP: begin
        if (tick) begin
          phase_nxt = phase_r + 2'h1;
          unique case (phase_r)
            2'h0: sda_oe_nxt = 1'b1;
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: sda_oe_nxt = 1'b0;   // sda rises while scl high
            2'h3: begin
              state_nxt = iscp_pkg::ISCP_H_IDLE;
              ready_nxt = 1'b1;
              done_nxt  = 1'b1;
              nack_nxt  = 1'b0;
            end
          endcase
        end
      end
    endcase
  end

  // registers; sda is synchronised since the device drives it too
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r   <= iscp_pkg::ISCP_H_IDLE;
      sda_q     <= 2'h3;
      qcnt_r    <= 16'h0000;
      phase_r   <= 2'h0;
      bit_r     <= 4'h0;
      tx_r      <= 9'h1ff;
      rx_r      <= 9'h000;
      scl_oe_r  <= 1'b0;
      sda_oe_r  <= 1'b0;
      ready_r   <= 1'b1;
      done_r    <= 1'b0;
      rx_data_r <= 8'h00;
      nack_r    <= 1'b0;
    end else if (ce) begin
      state_r   <= state_nxt;
      sda_q     <= {sda_q[0], link.sda};
      qcnt_r    <= (!active || tick) ? 16'h0000 : qcnt_r + 16'h0001;
      phase_r   <= phase_nxt;
      bit_r     <= bit_nxt;
      tx_r      <= tx_nxt;
      rx_r      <= rx_nxt;
      scl_oe_r  <= scl_oe_nxt;
      sda_oe_r  <= sda_oe_nxt;
      ready_r   <= ready_nxt;
      done_r    <= done_nxt;
      rx_data_r <= rx_data_nxt;
      nack_r    <= nack_nxt;
    end
  end

  assign link.m_scl_o  = 1'b0;
  assign link.m_scl_oe = scl_oe_r;
  assign link.m_sda_o  = 1'b0;
  assign link.m_sda_oe = sda_oe_r;
  assign cmd_ready     = ready_r;
  assign done          = done_r;
  assign rx_data       = rx_data_r;
  assign nack          = nack_r;

endmodule

`default_nettype wire

// File: core/iscp_if.sv
`timescale 1ns/100ps
`default_nettype none

interface iscp_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // open-drain wires: pulled high unless an enabled driver pulls low
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport device (input scl, input sda, output s_sda_o, output s_sda_oe);
  modport host (input sda, output m_scl_o, output m_scl_oe,
                output m_sda_o, output m_sda_oe);
endinterface

`default_nettype wire

// File: core/iscp_pkg.sv
package iscp_pkg;

  // how one select pin is strapped; bit1 = bus line, bit0 = high-ish
  typedef enum logic [1:0] {
    ISCP_CONN_GND    = 2'h0,
    ISCP_CONN_SUPPLY = 2'h1,
    ISCP_CONN_SCL    = 2'h2,
    ISCP_CONN_SDA    = 2'h3
  } iscp_conn_e;

  // byte level commands of the master end
  typedef enum logic [1:0] {
    ISCP_OP_START = 2'h0,
    ISCP_OP_WRITE = 2'h1,
    ISCP_OP_READ  = 2'h2,
    ISCP_OP_STOP  = 2'h3
  } iscp_op_e;

  typedef enum logic [5:0] {
    ISCP_D_IDLE = 6'h01,
    ISCP_D_ADDR = 6'h02,
    ISCP_D_RX   = 6'h04,
    ISCP_D_ACK  = 6'h08,
    ISCP_D_TX   = 6'h10,
    ISCP_D_MACK = 6'h20
  } iscp_dev_state_e;

  typedef enum logic [4:0] {
    ISCP_H_IDLE  = 5'h01,
    ISCP_H_START = 5'h02,
    ISCP_H_BIT   = 5'h04,
    ISCP_H_STOP  = 5'h08,
    ISCP_H_HOLD  = 5'h10
  } iscp_host_state_e;

endpackage

// File: verif/i2c_slave_command_pointer_bench.sv
`timescale 1ns/100ps
`default_nettype none

module i2c_slave_command_pointer_bench;
  localparam int         QTR = 8;
  localparam logic [6:0] DEV = 7'h6b;
  typedef struct packed {
    logic [1:0] hi;
    logic [1:0] mid;
    logic [1:0] lo;
    logic [6:0] addr;
  } iscp_row_s;
  // strap rows: 0 gnd, 1 supply, 2 clock line, 3 data line
  iscp_row_s rows [6] = '{{2'h0, 2'h2, 2'h0, 7'h10},
    {2'h1, 2'h3, 2'h1, 7'h17}, {2'h3, 2'h3, 2'h3, 7'h5f},
    {2'h0, 2'h0, 2'h2, 7'h28}, {2'h2, 2'h1, 2'h3, 7'h6b},
    {2'h3, 2'h0, 2'h0, 7'h64}};

  logic               clock, reset, ce, cmd_valid, cmd_last, cmd_ready;
  logic               done, nack, wr_strobe, busy, got_nack;
  iscp_pkg::iscp_op_e cmd_op;
  logic [7:0]         cmd_data, rd_data, wr_addr, wr_data, rd_addr;
  logic [7:0]         rx_data, got;
  logic [1:0]         s_hi, s_mid, s_lo;
  logic [7:0]         mem [256];
  int                 miscompares, samples_checked, n_wr, base;

  iscp_if iscp_if_i ();
  iscp_device iscp_device_i (.link(iscp_if_i), .clock(clock),
    .reset(reset), .ce(ce), .addr_select_pin_low(s_lo),
    .addr_select_pin_mid(s_mid), .addr_select_pin_high(s_hi),
    .rd_data(rd_data), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .busy(busy));
  iscp_host #(.QTR_CYC(QTR)) iscp_host_i (.link(iscp_if_i),
    .clock(clock), .reset(reset), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_last(cmd_last),
    .cmd_ready(cmd_ready), .done(done), .rx_data(rx_data), .nack(nack));
  iscp_chk iscp_chk_i (.clock(clock), .reset(reset),
    .scl(iscp_if_i.scl), .sda(iscp_if_i.sda),
    .s_sda_oe(iscp_if_i.s_sda_oe), .m_sda_oe(iscp_if_i.m_sda_oe),
    .m_scl_oe(iscp_if_i.m_scl_oe));

  // register file behind the device; known pattern so reads are checkable
  assign rd_data = mem[rd_addr];
  always @(posedge clock) begin
    if (wr_strobe === 1'b1) begin
      mem[wr_addr] <= wr_data;
      n_wr         <= n_wr + 1;
    end
  end

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // one host command, entered and left at a falling edge
  task automatic bus_op(input iscp_pkg::iscp_op_e op,
                        input logic [7:0] data, input logic last);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_data  = data;
    cmd_last  = last;
    while (cmd_ready !== 1'b1 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 4000) begin
      miscompares++;
      print_verdict();
    end
    got      = rx_data;
    got_nack = nack;
    @(negedge clock);
  endtask

  task automatic write_bytes(input logic [7:0] b[$]);
    bus_op(iscp_pkg::ISCP_OP_START, {DEV, 1'b0}, 1'b0);
    check({7'h00, got_nack}, 8'h00);
    foreach (b[i]) begin
      bus_op(iscp_pkg::ISCP_OP_WRITE, b[i], 1'b0);
      check({7'h00, got_nack}, 8'h00);
    end
  endtask

  // last byte gets the master nack so the device lets go of sda
  task automatic read_bytes(input logic [7:0] exp[$]);
    bus_op(iscp_pkg::ISCP_OP_START, {DEV, 1'b1}, 1'b0);
    check({7'h00, got_nack}, 8'h00);
    foreach (exp[i]) begin
      bus_op(iscp_pkg::ISCP_OP_READ, 8'h00, i == exp.size() - 1);
      check(got, exp[i]);
    end
  endtask

  task automatic stop();
    bus_op(iscp_pkg::ISCP_OP_STOP, 8'h00, 1'b0);
  endtask

  task automatic set_straps(input iscp_row_s r);
    s_hi  = r.hi;
    s_mid = r.mid;
    s_lo  = r.lo;
    repeat (4) @(negedge clock);
  endtask

  initial begin
    reset     = 1'b1;
    ce        = 1'b1;
    cmd_valid = 1'b0;
    cmd_op    = iscp_pkg::ISCP_OP_START;
    cmd_data  = 8'h00;
    cmd_last  = 1'b0;
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
    repeat (8) @(negedge clock);
    reset = 1'b0;
    // straps settle through their synchronisers before any traffic
    set_straps(rows[4]);
    check(rd_addr, 8'h00);
    check({7'h00, busy}, 8'h00);
    check({7'h00, cmd_ready}, 8'h01);
    // clock enable low freezes both ends: an offered start is not taken
    ce        = 1'b0;
    cmd_valid = 1'b1;
    repeat (4) @(negedge clock);
    check({7'h00, cmd_ready}, 8'h01);
    cmd_valid = 1'b0;
    ce        = 1'b1;
    @(negedge clock);
    check({7'h00, busy}, 8'h00);
    // a byte with no open transfer is refused and leaves the bus alone
    bus_op(iscp_pkg::ISCP_OP_WRITE, 8'h00, 1'b0);
    check({7'h00, got_nack}, 8'h01);
    // own address acked, neighbour address ignored
    foreach (rows[i]) begin
      set_straps(rows[i]);
      bus_op(iscp_pkg::ISCP_OP_START, {rows[i].addr, 1'b0}, 1'b0);
      check({7'h00, got_nack}, 8'h00);
      stop();
      bus_op(iscp_pkg::ISCP_OP_START, {rows[i].addr ^ 7'h01, 1'b0}, 1'b0);
      check({7'h00, got_nack}, 8'h01);
      stop();
    end
    set_straps(rows[4]);
    // burst that wraps inside the intensity group
    base = n_wr;
    write_bytes('{8'h12, 8'ha1, 8'hb2, 8'hc3});
    stop();
    check(mem[8'h12], 8'ha1);
    check(mem[8'h13], 8'hb2);
    check(mem[8'h10], 8'hc3);
    check(rd_addr, 8'h11);
    check(8'(n_wr - base), 8'h03);
    // read without setting the pointer continues where the write left it
    read_bytes('{8'h4b});
    stop();
    check(rd_addr, 8'h12);
    // command byte alone moves only the pointer
    base = n_wr;
    write_bytes('{8'h03});
    stop();
    check(rd_addr, 8'h03);
    check(8'(n_wr - base), 8'h00);
    // outside the group the pointer stands still
    write_bytes('{8'h0f, 8'h11, 8'h22});
    stop();
    check(mem[8'h0f], 8'h22);
    check(mem[8'h10], 8'hc3);
    check(rd_addr, 8'h0f);
    // pointer set then read through a repeated start, wrapping once
    write_bytes('{8'h13});
    check({7'h00, busy}, 8'h01);
    read_bytes('{8'hb2, 8'hc3, 8'h4b, 8'ha1});
    stop();
    check(rd_addr, 8'h13);
    // reset in the middle of a frame, then traffic again
    write_bytes('{8'h12});
    reset = 1'b1;
    repeat (8) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    check(rd_addr, 8'h00);
    write_bytes('{8'h10, 8'h77});
    stop();
    check(mem[8'h10], 8'h77);
    print_verdict();
  end
endmodule

`default_nettype wire

// File: verif/iscp_chk.sv
`timescale 1ns/100ps
`default_nettype none

module iscp_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_oe,
  input wire logic m_sda_oe,
  input wire logic m_scl_oe
);
  logic       scl_q_r;
  logic       sda_q_r;
  logic [3:0] bitcnt_r;
  logic       first_r;
  logic       hit_r;
  logic       rw_r;

  // wire events seen from the resolved lines
  wire scl_rise   = scl & ~scl_q_r;
  wire start_seen = scl & scl_q_r & sda_q_r & ~sda;
  wire stop_seen  = scl & scl_q_r & ~sda_q_r & sda;
  wire ack_rise   = scl_rise & (bitcnt_r == 4'h8);

  // idle level of both lines is high, so reset to high
  always_ff @(posedge clock) begin
    scl_q_r <= reset | scl;
    sda_q_r <= reset | sda;
  end

  // bit position inside the nine-bit byte slot
  always_ff @(posedge clock) begin
    if (reset | start_seen) begin
      bitcnt_r <= 4'h0;
    end else if (scl_rise) begin
      bitcnt_r <= (bitcnt_r == 4'h8) ? 4'h0 : bitcnt_r + 4'h1;
    end
  end

  // address byte flag; hit taken from the device's own ack
  always_ff @(posedge clock) begin
    if (reset | stop_seen) begin
      first_r <= 1'b0;
      hit_r   <= 1'b0;
    end else if (start_seen) begin
      first_r <= 1'b1;
    end else if (ack_rise & first_r) begin
      first_r <= 1'b0;
      hit_r   <= s_sda_oe;
    end
  end

  // direction bit is the eighth bit of the address byte
  always_ff @(posedge clock) begin
    if (reset | stop_seen) begin
      rw_r <= 1'b0;
    end else if (scl_rise & first_r & (bitcnt_r == 4'h7)) begin
      rw_r <= sda;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_addr_quiet: assert property (
    scl_rise && bitcnt_r != 4'h8 && (first_r || !rw_r) |-> !s_sda_oe)
    else $error("device drove sda during a written bit");
  a_write_ack: assert property (
    ack_rise && !first_r && hit_r && !rw_r |-> s_sda_oe && !sda)
    else $error("written data byte not acknowledged");
  a_read_release: assert property (
    ack_rise && !first_r && rw_r |-> !s_sda_oe)
    else $error("device held sda in master ack slot");
  a_quiet_other: assert property (
    !first_r && !hit_r |-> !s_sda_oe)
    else $error("device drove sda while not addressed");
  a_change_scl_low: assert property (
    $changed(s_sda_oe) |-> !scl)
    else $error("device changed sda while scl high");
  a_ack_held: assert property (
    ack_rise && s_sda_oe |-> s_sda_oe [*8])
    else $error("acknowledge dropped during clock high");
  a_start_free: assert property (
    start_seen |-> !s_sda_oe)
    else $error("device drove sda at a start");
  a_reset_idle: assert property (
    $fell(reset) |-> !s_sda_oe && !m_sda_oe && !m_scl_oe)
    else $error("lines not released after reset");
endmodule

`default_nettype wire
